// *** design/dac_event_flag_status.sv ***
// Summary of operation
// - pll locked bit shows lock live
// - sync lost latched after prior alignment
// - sync locked after quiet averaging cycles
// - fifo warning one at distance one
// - fifo warning two at distance two
// - write one clears only that flag
// - auto check pass latched on match
// - auto fail set, self-clears after eight consecutive good pairs
// - sample check fail latched until cleared
// - lock lost latched when pll unlocks
// - enable bit gates flag onto irq
module dac_event_flag_status #(
    parameter int unsigned SYNC_QUIET_AVG = flag_pkg::SYNC_QUIET_AVG_CYCLES,
    parameter int unsigned GOOD_PAIRS = flag_pkg::GOOD_PAIRS_TO_CLEAR,
    parameter int unsigned FIFO_DIST_W = flag_pkg::FIFO_DIST_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flag_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [flag_pkg::APB_DATA_W-1:0] pwdata,
    output logic [flag_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_lock_pin,
    input wire flag_pkg::sync_evt_t sync_evt,
    input wire logic [FIFO_DIST_W-1:0] fifo_distance,
    input wire flag_pkg::pattern_evt_t pattern_evt,
    output logic irq
);
    import flag_pkg::*;

    localparam int unsigned QW = $clog2(SYNC_QUIET_AVG + 1) + 1;
    localparam logic [QW-1:0] QUIET_LAST = QW'(SYNC_QUIET_AVG);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic pll_locked_s;
    logic pll_locked_d_reg;
    logic pll_locked_d_next;
    logic lock_lost_evt;

    sync_state_t sync_state_reg;
    sync_state_t sync_state_next;
    logic [QW-1:0] quiet_cnt_reg;
    logic [QW-1:0] quiet_cnt_next;
    logic sync_lost_evt;
    logic sync_locked;

    logic fifo_warn1;
    logic fifo_warn2;

    logic lock_lost_reg;
    logic lock_lost_next;
    logic sync_lost_reg;
    logic sync_lost_next;
    logic auto_pass_reg;
    logic auto_pass_next;
    logic auto_fail_reg;
    logic auto_fail_next;
    logic sample_fail_reg;
    logic sample_fail_next;
    logic auto_fail_selfclr;

    logic [7:0] lock_mask_reg;
    logic [7:0] lock_mask_next;
    logic [7:0] err_mask_reg;
    logic [7:0] err_mask_next;
    logic [7:0] lock_view;
    logic [7:0] err_view;

    logic [APB_ADDR_W-3:0] word_idx;
    logic aligned;
    logic hit_lock_mask;
    logic hit_err_mask;
    logic hit_lock_flags;
    logic hit_err_flags;
    logic addr_hit;
    logic wr_access;
    logic rd_setup;
    logic [7:0] clr_lock;
    logic [7:0] clr_err;
    logic [APB_DATA_W-1:0] prdata_reg;
    logic [APB_DATA_W-1:0] prdata_next;
    logic irq_reg;
    logic irq_next;

    ////////////////////////////////////////////////////////////////////////////
    // pll lock detector comes from the analog loop, so it is resynchronised
    pin_sync #(
        .WIDTH(1)
    ) pin_sync_i (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pll_lock_pin),
        .stable_out(pll_locked_s)
    );

    // falling edge of the settled level marks a loss of lock
    always_comb begin
        pll_locked_d_next = pll_locked_s;
        lock_lost_evt = pll_locked_d_reg && !pll_locked_s;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_locked_d_reg <= 1'b0;
        end else begin
            pll_locked_d_reg <= pll_locked_d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync alignment tracker: counts averaging cycles with no phase request;
    // a request in the same cycle as an average end wins, never counts quiet
    always_comb begin
        sync_state_next = sync_state_reg;
        quiet_cnt_next = quiet_cnt_reg;
        sync_lost_evt = 1'b0;
        case (sync_state_reg)
            SYNC_SEARCH: begin
                quiet_cnt_next = '0;
                if (!sync_evt.phase_adjust_req && sync_evt.avg_cycle_done) begin
                    quiet_cnt_next = QW'(1);
                    sync_state_next = (QUIET_LAST <= QW'(1)) ? SYNC_LOCKED : SYNC_QUIET;
                end
            end
            SYNC_QUIET: begin
                if (sync_evt.phase_adjust_req) begin
                    quiet_cnt_next = '0;
                    sync_state_next = SYNC_SEARCH;
                end else if (sync_evt.avg_cycle_done) begin
                    quiet_cnt_next = quiet_cnt_reg + 1'b1;
                    if (quiet_cnt_reg + 1'b1 >= QUIET_LAST) begin
                        sync_state_next = SYNC_LOCKED;
                    end
                end
            end
            SYNC_LOCKED: begin
                if (sync_evt.phase_adjust_req) begin
                    quiet_cnt_next = '0;
                    sync_state_next = SYNC_SEARCH;
                    sync_lost_evt = 1'b1;
                end
            end
            default: begin
                quiet_cnt_next = '0;
                sync_state_next = SYNC_SEARCH;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_state_reg <= SYNC_SEARCH;
            quiet_cnt_reg <= '0;
        end else begin
            sync_state_reg <= sync_state_next;
            quiet_cnt_reg <= quiet_cnt_next;
        end
    end

    assign sync_locked = (sync_state_reg == SYNC_LOCKED);

    ////////////////////////////////////////////////////////////////////////////
    // fifo pointer distance warnings are live, nothing latched
    assign fifo_warn1 = (fifo_distance == FIFO_DIST_W'(FIFO_WARN1_DIST));
    assign fifo_warn2 = (fifo_distance == FIFO_DIST_W'(FIFO_WARN2_DIST));

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, unmapped or misaligned gets pslverr
    assign word_idx = paddr[APB_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign hit_lock_mask = aligned && (word_idx == (APB_ADDR_W-2)'(IDX_LOCK_MASK));
    assign hit_err_mask = aligned && (word_idx == (APB_ADDR_W-2)'(IDX_ERR_MASK));
    assign hit_lock_flags = aligned && (word_idx == (APB_ADDR_W-2)'(IDX_LOCK_FLAGS));
    assign hit_err_flags = aligned && (word_idx == (APB_ADDR_W-2)'(IDX_ERR_FLAGS));
    assign addr_hit = hit_lock_mask || hit_err_mask || hit_lock_flags || hit_err_flags;
    assign wr_access = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // one-bits of a flag write become clear strobes, only on latched bits
    assign clr_lock = (wr_access && hit_lock_flags) ? (pwdata[7:0] & LOCK_W1C_BITS) : 8'h00;
    assign clr_err = (wr_access && hit_err_flags) ? (pwdata[7:0] & ERR_W1C_BITS) : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // latched flags: a new event in the clearing cycle survives the clear
    good_pair_counter #(
        .COUNT(GOOD_PAIRS)
    ) good_pair_counter_i (
        .pclk(pclk),
        .presetn(presetn),
        .armed(auto_fail_reg),
        .pair_ok(pattern_evt.pair_strobe),
        .pair_bad(pattern_evt.auto_fail),
        .clear_pulse(auto_fail_selfclr)
    );

    always_comb begin
        lock_lost_next = (lock_lost_reg && !clr_lock[BIT_LOCK_LOST]) || lock_lost_evt;
        sync_lost_next = (sync_lost_reg && !clr_lock[BIT_SYNC_LOST]) || sync_lost_evt;
        auto_pass_next = (auto_pass_reg && !clr_err[BIT_AUTO_PASS]) || pattern_evt.auto_pass;
        auto_fail_next = (auto_fail_reg && !clr_err[BIT_AUTO_FAIL] && !auto_fail_selfclr)
                         || pattern_evt.auto_fail;
        sample_fail_next = (sample_fail_reg && !clr_err[BIT_SAMPLE_FAIL])
                           || pattern_evt.sample_fail;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_lost_reg <= 1'b0;
            sync_lost_reg <= 1'b0;
            auto_pass_reg <= 1'b0;
            auto_fail_reg <= 1'b0;
            sample_fail_reg <= 1'b0;
        end else begin
            lock_lost_reg <= lock_lost_next;
            sync_lost_reg <= sync_lost_next;
            auto_pass_reg <= auto_pass_next;
            auto_fail_reg <= auto_fail_next;
            sample_fail_reg <= sample_fail_next;
        end
    end

    // register views as software sees them; unused bits read zero
    always_comb begin
        lock_view = 8'h00;
        lock_view[BIT_LOCK_LOST] = lock_lost_reg;
        lock_view[BIT_PLL_LOCKED] = pll_locked_s;
        lock_view[BIT_SYNC_LOST] = sync_lost_reg;
        lock_view[BIT_SYNC_LOCKED] = sync_locked;
        lock_view[BIT_FIFO_WARN1] = fifo_warn1;
        lock_view[BIT_FIFO_WARN2] = fifo_warn2;
        err_view = 8'h00;
        err_view[BIT_AUTO_PASS] = auto_pass_reg;
        err_view[BIT_AUTO_FAIL] = auto_fail_reg;
        err_view[BIT_SAMPLE_FAIL] = sample_fail_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // masks, read data and interrupt; read data is captured in setup so it
    // comes from a flop, at the cost of reflecting the setup-cycle state
    always_comb begin
        lock_mask_next = lock_mask_reg;
        err_mask_next = err_mask_reg;
        if (wr_access && hit_lock_mask) begin
            lock_mask_next = pwdata[7:0] & LOCK_MASK_BITS;
        end
        if (wr_access && hit_err_mask) begin
            err_mask_next = pwdata[7:0] & ERR_MASK_BITS;
        end
        prdata_next = prdata_reg;
        if (rd_setup) begin
            case (1'b1)
                hit_lock_mask: prdata_next = {24'h00_0000, lock_mask_reg};
                hit_err_mask: prdata_next = {24'h00_0000, err_mask_reg};
                hit_lock_flags: prdata_next = {24'h00_0000, lock_view};
                hit_err_flags: prdata_next = {24'h00_0000, err_view};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(lock_view & lock_mask_reg) || |(err_view & err_mask_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_mask_reg <= MASK_RESET;
            err_mask_reg <= MASK_RESET;
            prdata_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            lock_mask_reg <= lock_mask_next;
            err_mask_reg <= err_mask_next;
            prdata_reg <= prdata_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // read data must carry the live lock level seen at the setup edge
    a_pll_locked_view: assert property (rd_setup && hit_lock_flags
                                        |=> prdata[BIT_PLL_LOCKED] == $past(pll_locked_s))
        else $error("pll locked bit does not follow the lock level");

    // the loss is seen in the cycle the level falls, latched one edge later
    a_lock_lost_set: assert property ($fell(pll_locked_s) |=> lock_lost_reg)
        else $error("lock lost not latched after pll unlock");

    a_sync_lost_set: assert property (sync_locked && sync_evt.phase_adjust_req
                                      |=> sync_lost_reg && !sync_locked)
        else $error("sync lost not latched after loss of alignment");

    a_sync_locked_quiet: assert property ($rose(sync_locked) |-> $past(sync_evt.avg_cycle_done)
                                          && !$past(sync_evt.phase_adjust_req))
        else $error("sync locked without a quiet averaging cycle");

    a_sync_adjust_drops: assert property (sync_evt.phase_adjust_req |=> !sync_locked)
        else $error("sync locked held across a phase request");

    a_fifo_warn_one: assert property ((fifo_distance == FIFO_DIST_W'(1)) |-> lock_view[1:0] == 2'b10)
        else $error("fifo warning one wrong at distance one");

    a_fifo_warn_two: assert property ((fifo_distance == FIFO_DIST_W'(2)) |-> lock_view[1:0] == 2'b01)
        else $error("fifo warning two wrong at distance two");

    a_fifo_warn_live: assert property ((fifo_distance > FIFO_DIST_W'(2)) |-> lock_view[1:0] == 2'b00)
        else $error("fifo warning stuck with no matching distance");

    a_w1c_keeps_others: assert property (wr_access && hit_err_flags && !pwdata[BIT_SAMPLE_FAIL]
                                         && sample_fail_reg |=> sample_fail_reg)
        else $error("flag cleared without a one written");

    a_w1c_clears: assert property (wr_access && hit_lock_flags && pwdata[BIT_SYNC_LOST]
                                   && !sync_lost_evt |=> !sync_lost_reg)
        else $error("written one did not clear sync lost");

    a_auto_pass_set: assert property (pattern_evt.auto_pass |=> auto_pass_reg)
        else $error("auto check pass not latched");

    a_auto_fail_clr: assert property ((auto_fail_reg && !pattern_evt.auto_fail && pattern_evt.pair_strobe)
                                      [*8] |=> !auto_fail_reg)
        else $error("auto check fail not cleared after eight good pairs");

    a_sample_fail_hold: assert property (pattern_evt.sample_fail |=> sample_fail_reg ##1
                                         (sample_fail_reg || $past(clr_err[BIT_SAMPLE_FAIL])))
        else $error("sample check fail not held");

    a_irq_masked: assert property ((lock_mask_reg == 8'h00) && (err_mask_reg == 8'h00) |=> !irq)
        else $error("irq raised with every enable clear");

    c_sync_lock_cycle: cover property (sync_locked ##[1:50] sync_lost_reg);
    c_auto_fail_selfclr: cover property (auto_fail_reg ##1 auto_fail_selfclr ##1 !auto_fail_reg);
    c_irq_from_lock_lost: cover property (lock_lost_reg && lock_mask_reg[BIT_LOCK_LOST] ##1 irq);
    c_set_and_clear: cover property (clr_err[BIT_SAMPLE_FAIL] && pattern_evt.sample_fail);
endmodule

// *** design/flag_pkg.sv ***
package flag_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // apb geometry: register index, byte address is four times the index
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam logic [7:0] IDX_LOCK_MASK = 8'h04;
    localparam logic [7:0] IDX_ERR_MASK = 8'h05;
    localparam logic [7:0] IDX_LOCK_FLAGS = 8'h06;
    localparam logic [7:0] IDX_ERR_FLAGS = 8'h07;

    ////////////////////////////////////////////////////////////////////////////
    // bit positions in lock_and_fifo_flags and its mask
    localparam int unsigned BIT_LOCK_LOST = 7;
    localparam int unsigned BIT_PLL_LOCKED = 6;
    localparam int unsigned BIT_SYNC_LOST = 5;
    localparam int unsigned BIT_SYNC_LOCKED = 4;
    localparam int unsigned BIT_FIFO_WARN1 = 1;
    localparam int unsigned BIT_FIFO_WARN2 = 0;

    // bit positions in error_detect_flags and its mask
    localparam int unsigned BIT_AUTO_PASS = 4;
    localparam int unsigned BIT_AUTO_FAIL = 3;
    localparam int unsigned BIT_SAMPLE_FAIL = 2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and implemented-bit masks
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LOCK_MASK_BITS = 8'hF3;
    localparam logic [7:0] ERR_MASK_BITS = 8'h1C;
    localparam logic [7:0] LOCK_W1C_BITS = 8'hA0;
    localparam logic [7:0] ERR_W1C_BITS = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // counts
    localparam int unsigned GOOD_PAIRS_TO_CLEAR = 8;
    localparam int unsigned SYNC_QUIET_AVG_CYCLES = 3;
    localparam int unsigned FIFO_WARN1_DIST = 1;
    localparam int unsigned FIFO_WARN2_DIST = 2;
    localparam int unsigned FIFO_DIST_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // carriers and states
    typedef struct packed {
        logic avg_cycle_done;
        logic phase_adjust_req;
    } sync_evt_t;

    typedef struct packed {
        logic pair_strobe;
        logic auto_pass;
        logic auto_fail;
        logic sample_fail;
    } pattern_evt_t;

    typedef enum logic [2:0] {
        SYNC_SEARCH = 3'b001,
        SYNC_QUIET = 3'b010,
        SYNC_LOCKED = 3'b100
    } sync_state_t;

endpackage

// *** design/pin_sync.sv ***
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    ////////////////////////////////////////////////////////////////////////////
    // three stages; a level counts only once stages two and three agree,
    // so a glitch caught by the metastable stage never reaches the output
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                stable_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : stable_reg[i];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            stable_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_reg <= stable_next;
        end
    end

    assign stable_out = stable_reg;
endmodule

// *** design/good_pair_counter.sv ***
module good_pair_counter #(
    parameter int unsigned COUNT = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic armed,
    input wire logic pair_ok,
    input wire logic pair_bad,
    output logic clear_pulse
);
    localparam int unsigned CW = (COUNT > 1) ? $clog2(COUNT) : 1;
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    ////////////////////////////////////////////////////////////////////////////
    // consecutive good pairs; any bad pair or disarm restarts the run
    always_comb begin
        count_next = count_reg;
        clear_pulse = 1'b0;
        if (!armed || pair_bad) begin
            count_next = '0;
        end else if (pair_ok) begin
            if (count_reg == LAST) begin
                count_next = '0;
                clear_pulse = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// *** tb/dac_event_flag_status_test.sv ***
module dac_event_flag_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    import flag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // byte addresses are four times the register index
    localparam logic [11:0] A_LMASK = {2'b00, IDX_LOCK_MASK, 2'b00};
    localparam logic [11:0] A_EMASK = {2'b00, IDX_ERR_MASK, 2'b00};
    localparam logic [11:0] A_LFLG = {2'b00, IDX_LOCK_FLAGS, 2'b00};
    localparam logic [11:0] A_EFLG = {2'b00, IDX_ERR_FLAGS, 2'b00};
    localparam int unsigned TIMEOUT_CYCLES = 5000;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pll_lock_pin;
    sync_evt_t sync_evt;
    logic [3:0] fifo_distance;
    pattern_evt_t pattern_evt;
    logic irq;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    dac_event_flag_status #(.SYNC_QUIET_AVG(3), .GOOD_PAIRS(8), .FIFO_DIST_W(4)) dac_event_flag_status_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_lock_pin(pll_lock_pin), .sync_evt(sync_evt), .fifo_distance(fifo_distance),
        .pattern_evt(pattern_evt), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == TIMEOUT_CYCLES) begin
            errors = errors + 1;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // apb master: hold everything until pready is seen high, then release
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge keeps two transfers from assigning psel in one step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
        check({31'b0, e}, 32'h0000_0000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
        check({31'b0, e}, 32'h0000_0000);
        check({31'b0, pready}, 32'h0000_0001);
    endtask

    task automatic bad(input logic w, input logic [11:0] a);
        logic [31:0] r;
        logic e;
        xfer(w, a, 32'hFFFF_FFFF, r, e);
        check({31'b0, e}, 32'h0000_0001);
        if (!w)
            check(r, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // event stimulus: one-cycle pulses, or a run of n pair strobes, with an idle cycle after each
    task automatic pat(input pattern_evt_t v);
        pattern_evt <= v;
        @(posedge pclk);
        pattern_evt <= '0;
        @(posedge pclk);
    endtask

    task automatic pairs(input int n);
        pattern_evt <= 4'b1000;
        repeat (n) @(posedge pclk);
        pattern_evt <= '0;
        @(posedge pclk);
    endtask

    task automatic sync_pulse(input sync_evt_t v);
        sync_evt <= v;
        @(posedge pclk);
        sync_evt <= '0;
        @(posedge pclk);
    endtask

    // irq is registered, so let one more edge pass before looking
    task automatic chk_irq(input logic exp);
        @(posedge pclk);
        check({31'b0, irq}, {31'b0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pll_lock_pin = 1'b0;
        sync_evt = '0;
        fifo_distance = 4'h0;
        pattern_evt = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);

        rd(A_LFLG, 32'h0000_0000);
        rd(A_EFLG, 32'h0000_0000);
        wr(A_LMASK, 32'hFFFF_FFFF);
        rd(A_LMASK, 32'h0000_00F3);
        wr(A_EMASK, 32'hFFFF_FFFF);
        rd(A_EMASK, 32'h0000_001C);
        wr(A_LMASK, 32'h0000_0000);
        wr(A_EMASK, 32'h0000_0000);
        bad(1'b1, 12'h000);
        bad(1'b0, 12'h019);
        bad(1'b0, 12'h020);
        done("registers");

        pll_lock_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(A_LFLG, 32'h0000_0040);
        wr(A_LFLG, 32'h0000_0040);
        rd(A_LFLG, 32'h0000_0040);
        pll_lock_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(A_LFLG, 32'h0000_0080);
        done("pll");

        sync_pulse(2'b10);
        sync_pulse(2'b10);
        rd(A_LFLG, 32'h0000_0080);
        sync_pulse(2'b10);
        rd(A_LFLG, 32'h0000_0090);
        sync_pulse(2'b01);
        rd(A_LFLG, 32'h0000_00A0);
        wr(A_LFLG, 32'h0000_0000);
        rd(A_LFLG, 32'h0000_00A0);
        wr(A_LFLG, 32'h0000_0020);
        rd(A_LFLG, 32'h0000_0080);
        wr(A_LFLG, 32'h0000_0080);
        rd(A_LFLG, 32'h0000_0000);
        done("sync");

        for (int i = 0; i < 4; i++) begin
            fifo_distance <= i[3:0];
            repeat (2) @(posedge pclk);
            rd(A_LFLG, {30'b0, i == 1, i == 2});
        end
        fifo_distance <= 4'h0;
        done("fifo");

        pat(4'b0100);
        rd(A_EFLG, 32'h0000_0010);
        pat(4'b0001);
        rd(A_EFLG, 32'h0000_0014);
        pat(4'b0010);
        // a bad pair in mid-run must restart the good-pair count
        pairs(5);
        pat(4'b1010);
        pairs(7);
        rd(A_EFLG, 32'h0000_001C);
        pairs(1);
        rd(A_EFLG, 32'h0000_0014);
        wr(A_EFLG, 32'h0000_0010);
        rd(A_EFLG, 32'h0000_0004);
        // eight good pairs in an unbroken run clear the fail flag by itself
        pat(4'b0010);
        rd(A_EFLG, 32'h0000_000C);
        pairs(8);
        rd(A_EFLG, 32'h0000_0004);
        done("pattern");

        chk_irq(1'b0);
        wr(A_EMASK, 32'h0000_0008);
        chk_irq(1'b0);
        wr(A_EMASK, 32'h0000_0004);
        chk_irq(1'b1);
        wr(A_EFLG, 32'h0000_0004);
        chk_irq(1'b0);
        wr(A_LMASK, 32'h0000_0001);
        fifo_distance <= 4'h2;
        repeat (2) @(posedge pclk);
        chk_irq(1'b1);
        fifo_distance <= 4'h0;
        repeat (2) @(posedge pclk);
        chk_irq(1'b0);
        done("irq");

        // mid-run reset must drop latched flags and masks
        pat(4'b0001);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_LMASK, 32'h0000_0000);
        rd(A_EFLG, 32'h0000_0000);
        chk_irq(1'b0);
        done("reset");

        final_report();
    end
endmodule
